// [verilog/urm_pkg.sv]
// Package: register map, field positions and reset values of the serial port
package urm_pkg;
  localparam int ADDR_W = 8;
  localparam logic [31:0] BASE_ADDR = 32'h4030_0000;
  localparam logic [7:0] OFF_DATA = 8'h00;
  localparam logic [7:0] OFF_RX_ERR = 8'h04;
  localparam logic [7:0] OFF_TIMEOUT = 8'h0c;
  localparam logic [7:0] OFF_FLAGS = 8'h18;
  localparam logic [7:0] OFF_RX_LCR = 8'h1c;
  localparam logic [7:0] OFF_BAUD_INT = 8'h24;
  localparam logic [7:0] OFF_BAUD_FRAC = 8'h28;
  localparam logic [7:0] OFF_TX_LCR = 8'h2c;
  localparam logic [7:0] OFF_CONTROL = 8'h30;
  localparam logic [7:0] OFF_FIFO_LVL = 8'h34;
  localparam logic [7:0] OFF_INT_MASK = 8'h38;
  localparam logic [7:0] OFF_RAW_INT = 8'h3c;
  localparam logic [7:0] OFF_MASK_INT = 8'h40;
  localparam logic [7:0] OFF_INT_CLR = 8'h44;
  localparam logic [7:0] OFF_DMA = 8'h48;
  localparam logic [7:0] OFF_SOFT_FLOW = 8'h50;
  localparam logic [7:0] OFF_RESUME1 = 8'h54;
  localparam logic [7:0] OFF_RESUME2 = 8'h58;
  localparam logic [7:0] OFF_PAUSE1 = 8'h5c;
  localparam logic [7:0] OFF_PAUSE2 = 8'h60;
  localparam logic [31:0] RST_TIMEOUT = 32'h0000_01ff;
  localparam logic [31:0] RST_FLAGS = 32'h0000_1e90;
  localparam logic [31:0] RST_CONTROL = 32'h0004_0300;
  localparam logic [31:0] RST_FIFO_LVL = 32'h0000_0012;
  localparam logic [31:0] RST_ZERO = 32'h0000_0000;
  localparam logic [31:0] TIMEOUT_MASK = 32'h003f_ffff;
  // Data port error bits
  localparam int DP_FE = 8;
  localparam int DP_PE = 9;
  localparam int DP_BE = 10;
  localparam int DP_OE = 11;
  // Line control fields
  localparam int LCR_PEN = 1;
  localparam int LCR_EPS = 2;
  localparam int LCR_FEN = 4;
  localparam int LCR_SPS = 7;
  // Control fields
  localparam int CR_EN = 0;
  localparam int CR_TXE = 8;
  localparam int CR_RXE = 9;
  // Flag bits
  localparam int FR_BUSY = 3;
  localparam int FR_RXFE = 4;
  localparam int FR_TXFF = 5;
  localparam int FR_RXFF = 6;
  localparam int FR_TXFE = 7;
  // Interrupt bits
  localparam int INT_RX = 4;
  localparam int INT_TX = 5;
  localparam int INT_RT = 6;
  localparam int INT_FE = 7;
  localparam int INT_PE = 8;
  localparam int INT_BE = 9;
  localparam int INT_OE = 10;
  localparam int INT_W = 11;
  localparam int FIFO_AW = 4;
  localparam int FIFO_DEPTH = 16;
  localparam int RX_ENTRY_W = 11;
  localparam logic [4:0] DEPTH_ONE = 5'h01;
  localparam logic [4:0] DEPTH_FULL = 5'h10;
  localparam logic [15:0] BAUD_DEFAULT = 16'h0001;
  localparam logic [3:0] OVERSAMPLE_LAST = 4'hf;
  localparam logic [3:0] OVERSAMPLE_MID = 4'h7;
  localparam logic [3:0] DATA_BITS = 4'h8;
endpackage : urm_pkg

// [verilog/urm_fifo_if.sv]
// Interface: push and pop sides of one character queue
`timescale 1ns/1ps
interface urm_fifo_if #(parameter int W = 8);
  logic push;
  logic [W-1:0] wdata;
  logic pop;
  logic [W-1:0] rdata;
  logic [4:0] count;
  logic flush;
  modport owner (output push, output wdata, output pop, output flush, input rdata, input count);
  modport mem (input push, input wdata, input pop, input flush, output rdata, output count);
endinterface : urm_fifo_if

// [verilog/urm_fifo.sv]
// Small character queue whose head word comes out of a register
`timescale 1ns/1ps
module urm_fifo #(
  parameter int W = 8
) (
  input wire logic clk,
  input wire logic reset_n,
  urm_fifo_if.mem f
);
  import urm_pkg::*;
  logic [W-1:0] mem_q [FIFO_DEPTH];
  logic [FIFO_AW-1:0] wr_q;
  logic [FIFO_AW-1:0] rd_q;
  logic [4:0] count_q;
  logic do_push;
  logic do_pop;
  logic [FIFO_AW-1:0] rd_next;
  assign do_push = f.push && (count_q != DEPTH_FULL);
  assign do_pop = f.pop && (count_q != 5'h00);
  assign rd_next = do_pop ? rd_q + 1'b1 : rd_q;
  assign f.count = count_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else if (f.flush) begin
      wr_q <= '0;
      rd_q <= '0;
      count_q <= '0;
    end else begin
      if (do_push) wr_q <= wr_q + 1'b1;
      rd_q <= rd_next;
      count_q <= count_q + {4'h0, do_push} - {4'h0, do_pop};
    end
  end
  always_ff @(posedge clk) begin
    if (do_push) mem_q[wr_q] <= f.wdata;
  end
  // Head register: the written word bypasses into an empty or draining queue
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      f.rdata <= '0;
    end else if (do_push && (count_q - {4'h0, do_pop} == 5'h00)) begin
      f.rdata <= f.wdata;
    end else begin
      f.rdata <= mem_q[rd_next];
    end
  end
endmodule : urm_fifo

// [verilog/urm_uart.sv]
// Serial port register map, receive checker and transmitter
// =====================================================================
// Notes on behaviour
// RULE_01 - Data port reads head character, writes queue
// RULE_02 - Offset 0x04: read status, write clears errors
// RULE_03 - Bad stop bit sets framing flag
// RULE_04 - Parity mismatch sets parity flag
// RULE_05 - Line low whole frame sets break flag
// RULE_06 - Break pushes one zero, waits idle line
// RULE_07 - Overrun on full queue, clears when stored
// RULE_08 - Overrun leaves queue untouched
// RULE_09 - Error flags travel with their character; overrun bit 11 of the data port is read live from overrun_q
// RULE_10 - Timeout and flag registers reset values
// RULE_11 - Control and level select reset values
// RULE_12 - Block decoded at base, last at 0x60
// RULE_13 - Status registers read-only, clear write-only
// RULE_14 - Status bits 0..3 hold four errors
// RULE_15 - Reserved bits read zero, ignore writes
`timescale 1ns/1ps
module urm_uart (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_write,
  input wire logic bus_read,
  output logic [31:0] bus_rdata,
  input wire logic rx_pin,
  output logic tx_pin,
  output logic irq
);
  import urm_pkg::*;
  // =====================================================================
  // Bus decode
  logic hit;
  logic [ADDR_W-1:0] off;
  logic wr;
  logic rd;
  assign hit = (bus_addr[31:ADDR_W] == BASE_ADDR[31:ADDR_W]) && (bus_addr[1:0] == 2'b00); // RULE_12
  assign off = bus_addr[ADDR_W-1:0];
  assign wr = bus_write && hit;
  assign rd = bus_read && hit;
  function automatic logic wr_at(input logic [ADDR_W-1:0] o);
    wr_at = wr && (off == o);
  endfunction : wr_at
  // =====================================================================
  // Software registers
  logic [31:0] timeout_q, rx_lcr_q, baud_int_q, baud_frac_q, tx_lcr_q, control_q, fifo_lvl_q;
  logic [31:0] mask_q, dma_q, soft_flow_q, resume1_q, resume2_q, pause1_q, pause2_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      timeout_q <= RST_TIMEOUT; // RULE_10
      control_q <= RST_CONTROL; // RULE_11
      fifo_lvl_q <= RST_FIFO_LVL; // RULE_11
      rx_lcr_q <= RST_ZERO;
      baud_int_q <= RST_ZERO;
      baud_frac_q <= RST_ZERO;
      tx_lcr_q <= RST_ZERO;
      mask_q <= RST_ZERO;
      dma_q <= RST_ZERO;
      soft_flow_q <= RST_ZERO;
      resume1_q <= RST_ZERO;
      resume2_q <= RST_ZERO;
      pause1_q <= RST_ZERO;
      pause2_q <= RST_ZERO;
    end else begin
      if (wr_at(OFF_TIMEOUT)) timeout_q <= bus_wdata & TIMEOUT_MASK; // RULE_15
      if (wr_at(OFF_CONTROL)) control_q <= bus_wdata;
      if (wr_at(OFF_FIFO_LVL)) fifo_lvl_q <= bus_wdata;
      if (wr_at(OFF_RX_LCR)) rx_lcr_q <= bus_wdata;
      if (wr_at(OFF_BAUD_INT)) baud_int_q <= bus_wdata;
      if (wr_at(OFF_BAUD_FRAC)) baud_frac_q <= bus_wdata;
      if (wr_at(OFF_TX_LCR)) tx_lcr_q <= bus_wdata;
      if (wr_at(OFF_INT_MASK)) mask_q <= {21'h0, bus_wdata[INT_W-1:0]};
      if (wr_at(OFF_DMA)) dma_q <= bus_wdata;
      if (wr_at(OFF_SOFT_FLOW)) soft_flow_q <= bus_wdata;
      if (wr_at(OFF_RESUME1)) resume1_q <= bus_wdata;
      if (wr_at(OFF_RESUME2)) resume2_q <= bus_wdata;
      if (wr_at(OFF_PAUSE1)) pause1_q <= bus_wdata;
      if (wr_at(OFF_PAUSE2)) pause2_q <= bus_wdata; // RULE_12
    end
  end
  logic fifo_en;
  assign fifo_en = rx_lcr_q[LCR_FEN];
  // =====================================================================
  // Baud tick: sixteen ticks per bit, divisor from the integer register
  logic [15:0] baud_cnt_q;
  logic tick;
  logic [15:0] baud_div;
  assign baud_div = (baud_int_q[15:0] == 16'h0000) ? BAUD_DEFAULT : baud_int_q[15:0];
  assign tick = (baud_cnt_q == 16'h0000);
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) baud_cnt_q <= '0;
    else if (tick) baud_cnt_q <= baud_div - 16'h0001;
    else baud_cnt_q <= baud_cnt_q - 16'h0001;
  end
  // =====================================================================
  // Receive line synchroniser
  logic rx_s1_q, rx_s2_q;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= rx_pin;
      rx_s2_q <= rx_s1_q;
    end
  end
  // =====================================================================
  // Receiver
  typedef enum logic [2:0] {URM_RX_IDLE, URM_RX_START, URM_RX_DATA, URM_RX_PAR, URM_RX_STOP, URM_RX_WAIT_HIGH} urm_rx_e;
  urm_rx_e rx_st_q;
  logic [3:0] rx_os_q, rx_bit_q;
  logic [7:0] rx_shift_q;
  logic rx_par_err_q, rx_all_low_q;
  logic rx_done;
  logic [RX_ENTRY_W-1:0] rx_entry;
  logic rx_en;
  logic par_en;
  logic par_expect;
  assign rx_en = control_q[CR_EN] && control_q[CR_RXE];
  assign par_en = rx_lcr_q[LCR_PEN];
  function automatic logic parity_bit(input logic [7:0] d, input logic [31:0] lcr);
    if (lcr[LCR_SPS]) parity_bit = ~lcr[LCR_EPS];
    // Even parity sends the XOR of the data bits, odd parity its inverse
    else parity_bit = (^d) ^ ~lcr[LCR_EPS];
  endfunction : parity_bit
  assign par_expect = parity_bit(rx_shift_q, rx_lcr_q); // RULE_04
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      rx_st_q <= URM_RX_IDLE;
      rx_os_q <= '0;
      rx_bit_q <= '0;
      rx_shift_q <= '0;
      rx_par_err_q <= 1'b0;
      rx_all_low_q <= 1'b0;
    end else if (!rx_en) begin
      rx_st_q <= URM_RX_IDLE;
    end else if (tick) begin
      rx_os_q <= rx_os_q + 4'h1;
      unique case (rx_st_q)
        URM_RX_IDLE: begin
          rx_os_q <= '0;
          if (!rx_s2_q) rx_st_q <= URM_RX_START;
        end
        URM_RX_START: begin
          if (rx_os_q == OVERSAMPLE_MID) begin
            rx_os_q <= '0;
            rx_bit_q <= '0;
            rx_all_low_q <= 1'b1;
            rx_par_err_q <= 1'b0;
            rx_st_q <= rx_s2_q ? URM_RX_IDLE : URM_RX_DATA;
          end
        end
        URM_RX_DATA: begin
          if (rx_os_q == OVERSAMPLE_LAST) begin
            rx_shift_q <= {rx_s2_q, rx_shift_q[7:1]}; // RULE_08
            rx_all_low_q <= rx_all_low_q & ~rx_s2_q;
            rx_bit_q <= rx_bit_q + 4'h1;
            if (rx_bit_q == DATA_BITS - 4'h1) rx_st_q <= par_en ? URM_RX_PAR : URM_RX_STOP;
          end
        end
        URM_RX_PAR: begin
          if (rx_os_q == OVERSAMPLE_LAST) begin
            rx_par_err_q <= (rx_s2_q != par_expect); // RULE_04
            rx_all_low_q <= rx_all_low_q & ~rx_s2_q;
            rx_st_q <= URM_RX_STOP;
          end
        end
        URM_RX_STOP: begin
          if (rx_os_q == OVERSAMPLE_LAST) begin
            rx_st_q <= (rx_all_low_q && !rx_s2_q) ? URM_RX_WAIT_HIGH : URM_RX_IDLE; // RULE_06
          end
        end
        URM_RX_WAIT_HIGH: begin
          if (rx_s2_q) rx_st_q <= URM_RX_IDLE; // RULE_06
        end
      endcase
    end
  end
  logic rx_break;
  assign rx_done = tick && (rx_st_q == URM_RX_STOP) && (rx_os_q == OVERSAMPLE_LAST) && rx_en;
  assign rx_break = rx_all_low_q && !rx_s2_q; // RULE_05
  // Entry layout: {break, parity, framing, data}; a break stores an all-zero character
  assign rx_entry = rx_break ? {1'b1, 2'b00, 8'h00} // RULE_06
                             : {1'b0, rx_par_err_q, !rx_s2_q, rx_shift_q}; // RULE_03
  // =====================================================================
  // Receive queue
  urm_fifo_if #(.W(RX_ENTRY_W)) rxq ();
  urm_fifo #(.W(RX_ENTRY_W)) u_rx_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .f(rxq)
  );
  logic rx_full, rx_empty;
  logic [4:0] rx_limit;
  assign rx_limit = fifo_en ? DEPTH_FULL : DEPTH_ONE;
  assign rx_full = (rxq.count >= rx_limit);
  assign rx_empty = (rxq.count == 5'h00);
  assign rxq.push = rx_done && !rx_full; // RULE_08
  assign rxq.wdata = rx_entry;
  assign rxq.pop = rd && (off == OFF_DATA); // RULE_01
  assign rxq.flush = 1'b0;
  // =====================================================================
  // Error status: copy taken at each data read of a non-empty queue for the status register
  logic overrun_q;
  logic [3:0] rx_err_q;
  logic err_clr;
  assign err_clr = wr_at(OFF_RX_ERR); // RULE_02
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) overrun_q <= 1'b0;
    else if (rx_done && rx_full) overrun_q <= 1'b1; // RULE_07
    else if (rxq.push || err_clr) overrun_q <= 1'b0; // RULE_07
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) rx_err_q <= 4'h0;
    else if (rxq.pop && !rx_empty) rx_err_q <= {overrun_q, rxq.rdata[10:8]}; // RULE_14
    else if (err_clr) rx_err_q <= 4'h0; // RULE_02
  end
  // =====================================================================
  // Transmitter: queue fed by data port writes
  urm_fifo_if #(.W(8)) txq ();
  urm_fifo #(.W(8)) u_tx_fifo (
    .clk(clk),
    .reset_n(reset_n),
    .f(txq)
  );
  logic tx_full, tx_empty, tx_busy_q, tx_load;
  logic [4:0] tx_limit;
  logic [3:0] tx_os_q, tx_bit_q;
  logic [10:0] tx_shift_q;
  logic tx_en;
  assign tx_en = control_q[CR_EN] && control_q[CR_TXE];
  assign tx_limit = tx_lcr_q[LCR_FEN] ? DEPTH_FULL : DEPTH_ONE;
  assign tx_full = (txq.count >= tx_limit);
  assign tx_empty = (txq.count == 5'h00);
  assign txq.push = wr_at(OFF_DATA) && !tx_full; // RULE_01
  assign txq.wdata = bus_wdata[7:0];
  assign tx_load = tick && !tx_busy_q && !tx_empty && tx_en;
  assign txq.pop = tx_load;
  assign txq.flush = 1'b0;
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      tx_busy_q <= 1'b0;
      tx_os_q <= '0;
      tx_bit_q <= '0;
      tx_shift_q <= '1;
      tx_pin <= 1'b1;
    end else if (tx_load) begin
      tx_busy_q <= 1'b1;
      tx_os_q <= '0;
      tx_bit_q <= tx_lcr_q[LCR_PEN] ? 4'hb : 4'ha;
      tx_shift_q <= {1'b1, parity_bit(txq.rdata, tx_lcr_q), txq.rdata, 1'b0};
      if (!tx_lcr_q[LCR_PEN]) tx_shift_q <= {2'b11, txq.rdata, 1'b0};
    end else if (tick && tx_busy_q) begin
      tx_os_q <= tx_os_q + 4'h1;
      if (tx_os_q == 4'h0) tx_pin <= tx_shift_q[0];
      if (tx_os_q == OVERSAMPLE_LAST) begin
        tx_shift_q <= {1'b1, tx_shift_q[10:1]};
        tx_bit_q <= tx_bit_q - 4'h1;
        if (tx_bit_q == 4'h1) tx_busy_q <= 1'b0;
      end
    end
  end
  // =====================================================================
  // Interrupts: sticky raw bits, set wins over clear
  logic [INT_W-1:0] raw_q, raw_set, raw_clr;
  logic [INT_W-1:0] masked;
  always_comb begin
    raw_set = '0;
    raw_set[INT_RX] = rxq.push;
    raw_set[INT_TX] = tx_load && (txq.count == DEPTH_ONE);
    raw_set[INT_FE] = rxq.push && rx_entry[DP_FE];
    raw_set[INT_PE] = rxq.push && rx_entry[DP_PE];
    raw_set[INT_BE] = rxq.push && rx_entry[DP_BE];
    raw_set[INT_OE] = rx_done && rx_full;
  end
  assign raw_clr = wr_at(OFF_INT_CLR) ? bus_wdata[INT_W-1:0] : '0; // RULE_13
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) raw_q <= '0;
    else raw_q <= (raw_q & ~raw_clr) | raw_set;
  end
  assign masked = raw_q & mask_q[INT_W-1:0];
  assign irq = |masked;
  // =====================================================================
  // Flags and read mux
  logic [31:0] flags;
  always_comb begin
    flags = RST_FLAGS & 32'hffff_ff00;
    flags[FR_BUSY] = tx_busy_q;
    flags[FR_RXFE] = rx_empty;
    flags[FR_TXFF] = tx_full;
    flags[FR_RXFF] = rx_full;
    flags[FR_TXFE] = tx_empty;
  end
  always_ff @(posedge clk or negedge reset_n) begin
    if (!reset_n) begin
      bus_rdata <= '0;
    end else if (rd) begin
      unique case (off)
        OFF_DATA: bus_rdata <= {20'h0, overrun_q, rxq.rdata}; // RULE_09
        OFF_RX_ERR: bus_rdata <= {28'h0, rx_err_q}; // RULE_14
        OFF_TIMEOUT: bus_rdata <= timeout_q;
        OFF_FLAGS: bus_rdata <= flags; // RULE_10
        OFF_RX_LCR: bus_rdata <= rx_lcr_q;
        OFF_BAUD_INT: bus_rdata <= baud_int_q;
        OFF_BAUD_FRAC: bus_rdata <= baud_frac_q;
        OFF_TX_LCR: bus_rdata <= tx_lcr_q;
        OFF_CONTROL: bus_rdata <= control_q;
        OFF_FIFO_LVL: bus_rdata <= fifo_lvl_q;
        OFF_INT_MASK: bus_rdata <= mask_q;
        OFF_RAW_INT: bus_rdata <= {21'h0, raw_q}; // RULE_13
        OFF_MASK_INT: bus_rdata <= {21'h0, masked}; // RULE_13
        OFF_DMA: bus_rdata <= dma_q;
        OFF_SOFT_FLOW: bus_rdata <= soft_flow_q;
        OFF_RESUME1: bus_rdata <= resume1_q;
        OFF_RESUME2: bus_rdata <= resume2_q;
        OFF_PAUSE1: bus_rdata <= pause1_q;
        OFF_PAUSE2: bus_rdata <= pause2_q;
        default: bus_rdata <= '0; // RULE_15
      endcase
    end else begin
      bus_rdata <= '0;
    end
  end
endmodule : urm_uart

// [dv/urm_uart_sva.sv]
// Checker: bus-visible timing and field properties of the serial port
`timescale 1ns/1ps
module urm_uart_chk (
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic bus_write,
  input wire logic bus_read,
  input wire logic [31:0] bus_rdata,
  input wire logic rx_pin,
  input wire logic tx_pin,
  input wire logic irq
);
  import urm_pkg::*;
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  function automatic logic hit(input logic [7:0] o);
    return bus_addr == (BASE_ADDR | {24'h00_0000, o});
  endfunction : hit

  // ==========================================================
  // Read path
  a_rdata_idle: assert property (!bus_read |=> bus_rdata == 32'h0000_0000)
    else $error("read data driven without a read strobe");
  a_unmapped_zero: assert property (bus_read && bus_addr[31:8] != BASE_ADDR[31:8] |=> bus_rdata == 32'h0000_0000)
    else $error("out-of-block read returned data");
  a_flags_fixed: assert property (bus_read && hit(OFF_FLAGS) |=> bus_rdata[31:8] == 24'h00_001e)
    else $error("flag register upper bits wrong");
  a_data_rsvd: assert property (bus_read && hit(OFF_DATA) |=> bus_rdata[31:12] == 20'h0_0000)
    else $error("data port reserved bits set");
  a_status_rsvd: assert property (bus_read && hit(OFF_RX_ERR) |=> bus_rdata[31:4] == 28'h000_0000)
    else $error("receive status reserved bits set");
  a_clear_wonly: assert property (bus_read && hit(OFF_INT_CLR) |=> bus_rdata == 32'h0000_0000)
    else $error("write-only clear register read back data");
  a_timeout_rsvd: assert property (bus_read && hit(OFF_TIMEOUT) |=> bus_rdata[31:22] == 10'h000)
    else $error("timeout reserved bits set");
  // Clear then read two cycles later: no pop in between, so status must be empty
  a_err_cleared: assert property (bus_write && hit(OFF_RX_ERR) ##2 bus_read && hit(OFF_RX_ERR)
    |=> bus_rdata[3:0] == 4'h0) else $error("error flags survived a clear");
  a_tx_idle_rst: assert property ($rose(reset_n) |-> tx_pin)
    else $error("transmit line not idle after reset");

  c_flags_read: cover property (bus_read && hit(OFF_FLAGS));
  c_err_clear: cover property (bus_write && hit(OFF_RX_ERR));
  c_irq_up: cover property ($rose(irq));
endmodule : urm_uart_chk

bind urm_uart urm_uart_chk CHK (.clk(clk), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata),
  .bus_write(bus_write), .bus_read(bus_read), .bus_rdata(bus_rdata), .rx_pin(rx_pin), .tx_pin(tx_pin), .irq(irq));

// [dv/urm_line_model.sv]
// Remote character device on the far side of the serial line
`timescale 1ns/1ps
module urm_line_model #(
  parameter int BIT_CLKS = 16
) (
  input wire logic clk,
  input wire logic tx_pin,
  output logic rx_pin
);
  initial rx_pin = 1'b1;

  // Frame: start, eight data bits LSB first, optional parity, stop
  task automatic send(input logic [7:0] d, input logic pen, input logic par, input logic stop);
    logic [10:0] f;
    f = {stop, par, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      if (i != 9 || pen) begin
        rx_pin <= f[i];
        repeat (BIT_CLKS) @(posedge clk);
      end
    end
    rx_pin <= 1'b1;
    repeat (BIT_CLKS) @(posedge clk);
  endtask : send

  task automatic hold_low(input int bits);
    rx_pin <= 1'b0;
    repeat (bits * BIT_CLKS) @(posedge clk);
    rx_pin <= 1'b1;
    repeat (2 * BIT_CLKS) @(posedge clk);
  endtask : hold_low

  // Bit 8 of the result flags a missing frame or a bad stop bit
  task automatic catch(output logic [8:0] got);
    int n;
    n = 0;
    got = 9'h100;
    while (tx_pin !== 1'b0 && n < 4000) begin
      @(posedge clk);
      n++;
    end
    if (n < 4000) begin
      repeat (BIT_CLKS + BIT_CLKS / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
        got[i] = tx_pin;
        repeat (BIT_CLKS) @(posedge clk);
      end
      got[8] = ~tx_pin;
    end
  endtask : catch
endmodule : urm_line_model

// [dv/uart_register_map_and_data_port_bench.sv]
// Testbench: register map, receive errors, interrupts and transmit of the serial port
`timescale 1ns/1ps
module uart_register_map_and_data_port_bench;
  import urm_pkg::*;
  localparam logic [31:0] ALL = 32'hffff_ffff;
  logic clk = 1'b0;
  logic reset_n = 1'b0;
  logic [31:0] bus_addr = 32'h0000_0000;
  logic [31:0] bus_wdata = 32'h0000_0000;
  logic bus_write = 1'b0;
  logic bus_read = 1'b0;
  logic [31:0] bus_rdata;
  logic rx_pin;
  logic tx_pin;
  logic irq;
  logic [23:0] page = BASE_ADDR[31:8];
  logic [8:0] got;
  int error_cnt = 0;
  int total_checks = 0;
  logic [7:0] lcrs [4] = '{8'h16, 8'h16, 8'h12, 8'h96};
  logic pars [4] = '{1'b0, 1'b1, 1'b1, 1'b1};
  logic pes [4] = '{1'b0, 1'b1, 1'b0, 1'b1};

  urm_uart DUT (.clk(clk), .reset_n(reset_n), .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_write(bus_write),
    .bus_read(bus_read), .bus_rdata(bus_rdata), .rx_pin(rx_pin), .tx_pin(tx_pin), .irq(irq));
  urm_line_model #(.BIT_CLKS(16)) LINE (.clk(clk), .tx_pin(tx_pin), .rx_pin(rx_pin));

  always #5 clk = ~clk;

  // ==========================================================
  // Bus tasks: every access takes two cycles, so strobes never touch
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp) begin
      error_cnt++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : check

  task automatic wr(input logic [7:0] o, input logic [31:0] d);
    bus_addr <= {page, o};
    bus_wdata <= d;
    bus_write <= 1'b1;
    @(posedge clk);
    bus_write <= 1'b0;
    @(posedge clk);
  endtask : wr

  task automatic rdc(input logic [7:0] o, input logic [31:0] m, input logic [31:0] e);
    bus_addr <= {page, o};
    bus_read <= 1'b1;
    @(posedge clk);
    bus_read <= 1'b0;
    @(negedge clk);
    check(bus_rdata & m, e);
    @(posedge clk);
  endtask : rdc

  function automatic logic [31:0] rst_of(input logic [7:0] o);
    case (o)
      OFF_TIMEOUT: return RST_TIMEOUT;
      OFF_FLAGS: return RST_FLAGS;
      OFF_CONTROL: return RST_CONTROL;
      OFF_FIFO_LVL: return RST_FIFO_LVL;
      default: return RST_ZERO;
    endcase
  endfunction : rst_of

  task automatic results();
    if (error_cnt == 0 && total_checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : results

  initial begin
    repeat (50000) @(posedge clk);
    error_cnt++;
    results();
  end

  // ==========================================================
  // Main sequence
  initial begin
    repeat (5) @(posedge clk);
    reset_n <= 1'b1;
    @(posedge clk);
    // Data port skipped: reading it pops the queue
    for (int o = 4; o <= 100; o += 4) begin
      rdc(8'(o), ALL, rst_of(8'(o)));
    end
    wr(OFF_TIMEOUT, ALL);
    rdc(OFF_TIMEOUT, ALL, TIMEOUT_MASK);
    wr(OFF_FLAGS, 32'h0000_0000);
    rdc(OFF_FLAGS, ALL, RST_FLAGS);
    wr(OFF_RAW_INT, ALL);
    rdc(OFF_RAW_INT, ALL, RST_ZERO);
    wr(OFF_PAUSE2, 32'h0000_00a5);
    rdc(OFF_PAUSE2, 32'h0000_00ff, 32'h0000_00a5);
    rdc(8'h1a, ALL, RST_ZERO);
    page = 24'h40_3001;
    rdc(OFF_FLAGS, ALL, RST_ZERO);
    page = BASE_ADDR[31:8];
    wr(OFF_BAUD_INT, 32'h0000_0001);
    wr(OFF_CONTROL, 32'h0000_0301);
    wr(OFF_RX_LCR, 32'h0000_0010);
    LINE.send(8'h5a, 1'b0, 1'b0, 1'b1);
    rdc(OFF_DATA, ALL, 32'h0000_005a);
    // Even parity with a good and a bad bit, then odd parity good and stick parity bad
    for (int i = 0; i < 4; i++) begin
      wr(OFF_RX_LCR, {24'h00_0000, lcrs[i]});
      LINE.send(8'h03, 1'b1, pars[i], 1'b1);
      rdc(OFF_DATA, ALL, 32'h0000_0003 | (32'(pes[i]) << 9));
    end
    wr(OFF_RX_LCR, 32'h0000_0010);
    LINE.send(8'h81, 1'b0, 1'b0, 1'b0);
    rdc(OFF_DATA, ALL, 32'h0000_0181);
    rdc(OFF_RX_ERR, ALL, 32'h0000_0001);
    wr(OFF_RX_ERR, 32'h0000_0000);
    rdc(OFF_RX_ERR, ALL, RST_ZERO);
    LINE.hold_low(14);
    rdc(OFF_DATA, ALL, 32'h0000_0400);
    rdc(OFF_FLAGS, 32'h0000_0010, 32'h0000_0010);
    rdc(OFF_RX_ERR, ALL, 32'h0000_0004);
    wr(OFF_RX_ERR, 32'h0000_0000);
    // Seventeen characters into a sixteen-deep queue
    for (int i = 0; i < 17; i++) begin
      LINE.send(8'h20 + 8'(i), 1'b0, 1'b0, 1'b1);
    end
    rdc(OFF_FLAGS, 32'h0000_0040, 32'h0000_0040);
    rdc(OFF_DATA, ALL, 32'h0000_0820);
    for (int i = 1; i < 16; i++) begin
      rdc(OFF_DATA, 32'h0000_00ff, 32'h0000_0020 + i);
    end
    rdc(OFF_FLAGS, 32'h0000_0010, 32'h0000_0010);
    rdc(OFF_RX_ERR, 32'h0000_0008, 32'h0000_0008);
    LINE.send(8'h77, 1'b0, 1'b0, 1'b1);
    rdc(OFF_DATA, ALL, 32'h0000_0077);
    wr(OFF_RX_ERR, 32'h0000_0000);
    wr(OFF_INT_CLR, 32'h0000_07ff);
    LINE.send(8'h81, 1'b0, 1'b0, 1'b0);
    rdc(OFF_RAW_INT, 32'h0000_0080, 32'h0000_0080);
    check({31'h0, irq}, 32'h0000_0000);
    wr(OFF_INT_MASK, 32'h0000_0080);
    check({31'h0, irq}, 32'h0000_0001);
    rdc(OFF_MASK_INT, ALL, 32'h0000_0080);
    wr(OFF_INT_CLR, 32'h0000_0080);
    rdc(OFF_RAW_INT, 32'h0000_0080, RST_ZERO);
    check({31'h0, irq}, 32'h0000_0000);
    wr(OFF_DATA, 32'h0000_01c3);
    LINE.catch(got);
    check({23'h0, got}, 32'h0000_00c3);
    results();
  end
endmodule : uart_register_map_and_data_port_bench
